// File: error_record_map.vh
// register offsets, field positions and reset values of the error record
`ifndef ERROR_RECORD_MAP_VH
`define ERROR_RECORD_MAP_VH
`define ERR_FEATURE_OFFSET     12'h000
`define ERR_CONTROL_OFFSET     12'h008
`define ERR_STATUS_OFFSET      12'h010
`define CTL_REPORTING_EN_BIT   0
`define CTL_UNC_REC_BIT        2
`define CTL_FAULT_BIT          3
`define CTL_CORR_FAULT_BIT     8
`define CTL_DEF_REC_BIT        10
`define ST_VALID_BIT           30
`define ST_UNCORR_BIT          29
`define ST_REPORTED_BIT        28
`define ST_OVERFLOW_BIT        27
`define ST_CORRECTED_BIT       25
`define ST_DEFERRED_BIT        23
`define CTL_RESET              11'h000
`define FEATURE_VALUE          64'h0000_0000_0000_0aa2
`define FEAT_BOTH_ACCESSES     2'h2
`endif

// File: error_irq_gen.v
// interrupt forming from enables and recorded error classes
`timescale 1ns/1ps
module error_irq_gen (
    // clock and reset
    input  wire        sys_clk,
    input  wire        nrst,
    // enables
    input  wire        fault_irq_en,
    input  wire        corrected_fault_irq_en,
    input  wire        uncorrected_recovery_irq_en,
    input  wire        deferred_recovery_irq_en,
    // recorded events this cycle
    input  wire        rec_uncorr,
    input  wire        rec_deferred,
    input  wire        rec_corrected,
    input  wire        cnt_overflow,
    // interrupts
    output reg         fault_irq_ff,
    output reg         recovery_irq_ff
);
    parameter HAS_COUNTERS = 1'b1;
    wire corr_event;
    wire nxt_fault;
    wire nxt_recovery;
    assign corr_event   = HAS_COUNTERS ? cnt_overflow : rec_corrected;
    // events arrive regardless of syndrome being kept or dropped
    assign nxt_fault    = (fault_irq_en & (rec_uncorr | rec_deferred))
                        | (corrected_fault_irq_en & corr_event);
    assign nxt_recovery = (uncorrected_recovery_irq_en & rec_uncorr)
                        | (deferred_recovery_irq_en & rec_deferred);
    always @(posedge sys_clk) begin
        if (!nrst) begin
            fault_irq_ff    <= 1'b0;
            recovery_irq_ff <= 1'b0;
        end else begin
            fault_irq_ff    <= nxt_fault;
            recovery_irq_ff <= nxt_recovery;
        end
    end
endmodule // error_irq_gen

// File: error_record_control_status.v
// error record control and primary status register bank
`timescale 1ns/1ps
`include "error_record_map.vh"
module error_record_control_status (
    // clock and reset
    input  wire        sys_clk,
    input  wire        nrst,
    // register access
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [11:0] reg_addr,
    input  wire [63:0] reg_wdata,
    output reg  [63:0] reg_rdata_ff,
    // error detection from the node
    input  wire        det_valid,
    input  wire        det_corrected,
    input  wire        det_deferred,
    input  wire        det_is_write,
    input  wire        cnt_overflow,
    // in-band response to the requester and check code enable
    output reg         inband_resp_ff,
    output reg         check_code_en_ff,
    // interrupts
    output wire        fault_irq_ff,
    output wire        recovery_irq_ff
);
    reg  [10:0] ctl_ff;
    reg  [10:0] nxt_ctl;
    reg         valid_ff;
    reg         uncorr_ff;
    reg         reported_ff;
    reg         deferred_ff;
    reg         corrected_ff;
    reg         overflow_ff;
    reg         nxt_valid;
    reg         nxt_uncorr;
    reg         nxt_reported;
    reg         nxt_deferred;
    reg         nxt_corrected;
    reg         nxt_overflow;
    reg  [63:0] nxt_rdata;
    wire        rec_en;
    wire        rec_uncorr;
    wire        rec_deferred;
    wire        rec_corrected;
    wire        ovf_rec;
    wire        wr_ctl;
    wire        wr_st;
    wire        clr_v;
    wire        clr_u;
    wire        clr_r;
    wire        clr_d;
    wire        clr_c;
    wire        clr_o;
    wire        v_blocked;
    wire [10:0] ctl_mask;

    // only enables that the feature register advertises are storage
    assign ctl_mask = (11'h1 << `CTL_REPORTING_EN_BIT) | (11'h1 << `CTL_UNC_REC_BIT)
                    | (11'h1 << `CTL_FAULT_BIT) | (11'h1 << `CTL_CORR_FAULT_BIT)
                    | (11'h1 << `CTL_DEF_REC_BIT);
    assign wr_ctl = reg_wr & (reg_addr == `ERR_CONTROL_OFFSET);
    assign wr_st  = reg_wr & (reg_addr == `ERR_STATUS_OFFSET);

    // detection qualified by reporting enable; reads and writes alike
    assign rec_en        = det_valid & ctl_ff[`CTL_REPORTING_EN_BIT];
    assign rec_uncorr    = rec_en & ~det_corrected & ~det_deferred;
    assign rec_deferred  = rec_en & ~det_corrected & det_deferred;
    assign rec_corrected = rec_en & det_corrected;
    assign ovf_rec       = cnt_overflow & ctl_ff[`CTL_REPORTING_EN_BIT];

    // w1c strobes: zero keeps, one clears
    assign clr_v = wr_st & reg_wdata[`ST_VALID_BIT];
    assign clr_o = wr_st & valid_ff & reg_wdata[`ST_OVERFLOW_BIT];
    assign clr_u = wr_st & valid_ff & reg_wdata[`ST_UNCORR_BIT]
                 & ~(overflow_ff & ~clr_o);
    assign clr_d = wr_st & valid_ff & reg_wdata[`ST_DEFERRED_BIT]
                 & ~(overflow_ff & ~clr_o);
    assign clr_c = wr_st & valid_ff & reg_wdata[`ST_CORRECTED_BIT]
                 & ~(overflow_ff & ~clr_o);
    // reported flag writable only once uncorrected flag is set
    assign clr_r = wr_st & valid_ff & uncorr_ff & ~clr_u
                 & reg_wdata[`ST_REPORTED_BIT];
    // valid clear refused while a class flag survives the write
    assign v_blocked = (uncorr_ff & ~clr_u) | (deferred_ff & ~clr_d)
                     | (corrected_ff & ~clr_c);

    always @* begin
        nxt_ctl = ctl_ff;
        if (wr_ctl) begin
            nxt_ctl = reg_wdata[10:0] & ctl_mask;
        end
    end

    // set wins over a clear arriving in the same cycle
    always @* begin
        nxt_valid     = valid_ff;
        nxt_uncorr    = uncorr_ff;
        nxt_reported  = reported_ff;
        nxt_deferred  = deferred_ff;
        nxt_corrected = corrected_ff;
        nxt_overflow  = overflow_ff;
        if (clr_v && !v_blocked) begin
            nxt_valid = 1'b0;
        end
        if (clr_u) begin
            nxt_uncorr = 1'b0;
        end
        if (clr_r || clr_u) begin
            nxt_reported = 1'b0;
        end
        if (clr_d) begin
            nxt_deferred = 1'b0;
        end
        if (clr_c) begin
            nxt_corrected = 1'b0;
        end
        if (clr_o) begin
            nxt_overflow = 1'b0;
        end
        if (rec_en) begin
            nxt_valid = 1'b1;
            if (valid_ff && !(det_corrected && ovf_rec == 1'b0 && 1'b0)) begin
                nxt_overflow = 1'b1;
            end
        end
        if (ovf_rec) begin
            nxt_overflow = 1'b1;
        end
        if (rec_uncorr) begin
            nxt_uncorr   = 1'b1;
            // response always enabled in this node, so it is reported
            nxt_reported = 1'b1;
        end
        if (rec_deferred) begin
            nxt_deferred = 1'b1;                                        // deferred not reported
        end
        if (rec_corrected) begin
            nxt_corrected = 1'b1;
        end
    end

    always @* begin
        nxt_rdata = 64'h0000_0000_0000_0000;
        case (reg_addr)
            `ERR_FEATURE_OFFSET: begin
                nxt_rdata = `FEATURE_VALUE;
            end
            `ERR_CONTROL_OFFSET: begin
                nxt_rdata[10:0] = ctl_ff;
            end
            `ERR_STATUS_OFFSET: begin
                nxt_rdata[`ST_VALID_BIT]     = valid_ff;
                // unknown fields while invalid are returned as zero
                nxt_rdata[`ST_UNCORR_BIT]    = valid_ff & uncorr_ff;
                nxt_rdata[`ST_REPORTED_BIT]  = valid_ff & uncorr_ff & reported_ff;
                nxt_rdata[`ST_OVERFLOW_BIT]  = valid_ff & overflow_ff;
                nxt_rdata[`ST_CORRECTED_BIT] = valid_ff & corrected_ff;
                nxt_rdata[`ST_DEFERRED_BIT]  = valid_ff & deferred_ff;
            end
            default: begin
                nxt_rdata = 64'h0000_0000_0000_0000;
            end
        endcase
    end

    always @(posedge sys_clk) begin
        if (!nrst) begin
            ctl_ff           <= `CTL_RESET;
            valid_ff         <= 1'b0;
            uncorr_ff        <= 1'b0;
            reported_ff      <= 1'b0;
            deferred_ff      <= 1'b0;
            corrected_ff     <= 1'b0;
            overflow_ff      <= 1'b0;
            reg_rdata_ff     <= 64'h0000_0000_0000_0000;
            inband_resp_ff   <= 1'b0;
            check_code_en_ff <= 1'b0;
        end else begin
            ctl_ff           <= nxt_ctl;
            valid_ff         <= nxt_valid;
            uncorr_ff        <= nxt_uncorr;
            reported_ff      <= nxt_reported;
            deferred_ff      <= nxt_deferred;
            corrected_ff     <= nxt_corrected;
            overflow_ff      <= nxt_overflow;
            if (reg_rd) begin
                reg_rdata_ff <= nxt_rdata;
            end
            inband_resp_ff   <= rec_uncorr;
            // check codes kept correct on writes regardless of reporting
            check_code_en_ff <= det_is_write | 1'b1;
        end
    end

    error_irq_gen u_irq (
        .sys_clk                     (sys_clk),
        .nrst                        (nrst),
        .fault_irq_en                (ctl_ff[`CTL_FAULT_BIT]),
        .corrected_fault_irq_en      (ctl_ff[`CTL_CORR_FAULT_BIT]),
        .uncorrected_recovery_irq_en (ctl_ff[`CTL_UNC_REC_BIT]),
        .deferred_recovery_irq_en    (ctl_ff[`CTL_DEF_REC_BIT]),
        .rec_uncorr                  (rec_uncorr),
        .rec_deferred                (rec_deferred),
        .rec_corrected               (rec_corrected),
        .cnt_overflow                (ovf_rec),
        .fault_irq_ff                (fault_irq_ff),
        .recovery_irq_ff             (recovery_irq_ff)
    );
endmodule // error_record_control_status

// File: error_record_checker_properties.sv
// assertion checker for the error record register bank
`timescale 1ns/1ps
module error_record_checker (
    // clock and reset
    input wire        sys_clk,
    input wire        nrst,
    // watched ports
    input wire        reg_wr,
    input wire [11:0] reg_addr,
    input wire [63:0] reg_wdata,
    input wire        det_valid,
    input wire        det_corrected,
    input wire        det_deferred,
    input wire        cnt_overflow,
    input wire        inband_resp_ff,
    input wire        check_code_en_ff,
    input wire        fault_irq_ff,
    input wire        recovery_irq_ff
);
    reg  [10:0] ctl_ff;
    wire        unc = ctl_ff[0] & det_valid & ~det_corrected & ~det_deferred;
    wire        dfr = ctl_ff[0] & det_valid & ~det_corrected & det_deferred;
    // shadow of the control register
    always @(posedge sys_clk) begin
        if (!nrst)
            ctl_ff <= 11'h000;
        else if (reg_wr && reg_addr == 12'h008)
            ctl_ff <= reg_wdata[10:0];
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    property p_ui; unc |=> recovery_irq_ff == $past(ctl_ff[2]); endproperty
    a_ui: assert property (p_ui) else $error("recovery irq on uncorrected");
    property p_dui; dfr |=> recovery_irq_ff == $past(ctl_ff[10]); endproperty
    a_dui: assert property (p_dui) else $error("recovery irq on deferred");
    property p_fi; unc || dfr |=> fault_irq_ff == ($past(ctl_ff[3])
        | $past(ctl_ff[8] & ctl_ff[0] & cnt_overflow)); endproperty
    a_fi: assert property (p_fi) else $error("fault irq on record");
    property p_cfi; ctl_ff[0] && cnt_overflow && !unc && !dfr |=> fault_irq_ff == $past(ctl_ff[8]);
    endproperty
    a_cfi: assert property (p_cfi) else $error("fault irq on overflow");
    property p_ed; !ctl_ff[0] |=> !fault_irq_ff && !recovery_irq_ff && !inband_resp_ff; endproperty
    a_ed: assert property (p_ed) else $error("signal while reporting off");
    property p_resp; unc |=> inband_resp_ff; endproperty
    a_resp: assert property (p_resp) else $error("missing in-band response");
    property p_noresp; inband_resp_ff |-> $past(unc); endproperty
    a_noresp: assert property (p_noresp) else $error("stray in-band response");
    property p_ccode; $past(nrst) |-> check_code_en_ff; endproperty
    a_ccode: assert property (p_ccode) else $error("check codes off");
endmodule // error_record_checker

bind error_record_control_status error_record_checker chk_u (
    .sys_clk, .nrst, .reg_wr, .reg_addr, .reg_wdata, .det_valid, .det_corrected,
    .det_deferred, .cnt_overflow, .inband_resp_ff, .check_code_en_ff, .fault_irq_ff,
    .recovery_irq_ff
);

// File: error_record_control_status_bench.sv
// self-checking bench for the error record register bank
`timescale 1ns/1ps
module error_record_control_status_bench;
    // clock, reset and stimulus
    reg          sys_clk = 1'b0;
    reg          nrst = 1'b0;
    reg          reg_wr = 1'b0, reg_rd = 1'b0, det_valid = 1'b0, det_corrected = 1'b0;
    reg          det_deferred = 1'b0, det_is_write = 1'b0, cnt_overflow = 1'b0;
    reg  [11:0]  reg_addr = 12'h000;
    reg  [63:0]  reg_wdata = 64'h0;
    wire [63:0]  reg_rdata_ff;
    wire         inband_resp_ff, check_code_en_ff, fault_irq_ff, recovery_irq_ff;
    logic [63:0] exp_q[$];
    integer      bad_count = 0, samples_checked = 0, cycles = 0, seed = 32'hb0b9, i, rnd;
    reg          rd_s = 1'b0, ev_s = 1'b0, k, f;
    reg  [2:0]   e;
    reg  [63:0]  c, base;
    always #5 sys_clk = ~sys_clk;
    error_record_control_status dut_u (.sys_clk, .nrst, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata_ff, .det_valid, .det_corrected, .det_deferred, .det_is_write,
        .cnt_overflow, .inband_resp_ff, .check_code_en_ff, .fault_irq_ff, .recovery_irq_ff);
    task chk(input [63:0] seen, input [63:0] exp, input string what);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task close_out;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one cycle of stimulus, access type random
    task op(input w, r, input [11:0] a, input [63:0] d, input v, kk, ff, o);
        @(negedge sys_clk);
        rnd = $random(seed);
        {reg_wr, reg_rd, reg_addr, reg_wdata, det_valid, det_corrected, det_deferred,
            cnt_overflow, det_is_write} = {w, r, a, d, v, kk, ff, o, rnd[0]};
    endtask
    task wr(input [11:0] a, input [63:0] d);
        op(1, 0, a, d, 0, 0, 0, 0);
    endtask
    task rd(input [11:0] a, input [63:0] x);
        op(0, 1, a, {$random(seed), $random(seed)}, 0, 0, 0, 0);
        exp_q.push_back(x);
    endtask
    task ev(input v, kk, ff, o, input [2:0] x);
        op(0, 0, 12'h000, 64'h0, v, kk, ff, o);
        exp_q.push_back({61'h0, x});
    endtask
    // results appear one cycle after the request
    always @(posedge sys_clk) begin
        rd_s <= reg_rd;
        ev_s <= det_valid | cnt_overflow;
        cycles <= cycles + 1;
    end
    always @(negedge sys_clk) begin
        if (rd_s)
            chk(reg_rdata_ff, exp_q.pop_front(), "read data");
        if (ev_s)
            chk({61'h0, fault_irq_ff, recovery_irq_ff, inband_resp_ff}, exp_q.pop_front(), "irqs");
        if (cycles > 3000) begin
            bad_count = bad_count + 1;
            close_out;
        end
    end
    initial begin
        repeat (16) @(negedge sys_clk);
        nrst = 1'b1;
        rd(12'h000, 64'haa2);
        chk({63'h0, check_code_en_ff}, 64'h1, "check code enable");
        rd(12'h008, 64'h0);
        rd(12'h010, 64'h0);
        rd(12'h018, 64'h0);
        ev(1, 0, 0, 0, 3'b000);
        rd(12'h010, 64'h0);
        wr(12'h008, {64{1'b1}});
        rd(12'h008, 64'h50d);
        for (i = 0; i < 9; i = i + 1) begin
            c = {$random(seed), $random(seed)} | 64'h1;
            wr(12'h008, c);
            k = (i % 3 == 1);
            f = (i % 3 == 2);
            e = {~k & c[3], ~k & (f ? c[10] : c[2]), ~k & ~f};
            base = k ? 64'h4200_0000 : f ? 64'h4080_0000 : 64'h7000_0000;
            ev(1, k, f, 0, e);
            ev(1, k, f, 0, e);
            ev(0, 0, 0, 1, {c[8], 2'b00});
            rd(12'h010, base | 64'h0800_0000);
            wr(12'h010, {64{1'b1}});
            rd(12'h010, 64'h0);
        end
        ev(1, 0, 0, 0, {c[3], c[2], 1'b1});
        rd(12'h010, 64'h7000_0000);
        wr(12'h010, 64'h4000_0000);
        wr(12'h010, 64'h0);
        rd(12'h010, 64'h7000_0000);
        wr(12'h010, 64'h2000_0000);
        rd(12'h010, 64'h4000_0000);
        wr(12'h010, 64'h4000_0000);
        wr(12'h010, 64'h3000_0000);
        rd(12'h010, 64'h0);
        op(0, 0, 12'h000, 64'h0, 0, 0, 0, 0);
        repeat (3) @(posedge sys_clk);
        close_out;
    end
endmodule // error_record_control_status_bench
